/* core/ihs_consts.vh */
`ifndef IHS_CONSTS_VH
`define IHS_CONSTS_VH
`define IHS_IDX_PORT      16'h03e0
`define IHS_IDX_PORT_ALT  16'h03e2
`define IHS_PORT_ODD      16'h0001
`define IHS_ATA_ADDR0     16'h03f7
`define IHS_ATA_ADDR1     16'h0377
`define IHS_SOCK_STRIDE   64
`define IHS_IDX_WIN_EN    7'h06
`define IHS_IDX_IO_CTL    7'h07
`define IHS_IDX_IO_WIN    7'h08
`define IHS_IO_WIN_STEP   4
`define IHS_IDX_MEM_START 7'h10
`define IHS_IDX_MEM_STOP  7'h11
`define IHS_IDX_MEM_CTL   7'h12
`define IHS_IDX_SEC_INDEX 7'h2e
`define IHS_IDX_SEC_DATA  7'h2f
`define IHS_IDX_TIM       7'h3a
`define IHS_TIM_STEP      3
`define IHS_SOCK_MASK     7'h3f
`define IHS_RF_DEPTH      128
`define IHS_EXT_DEPTH     16
`define IHS_EXT_STAT      4'h0
`define IHS_EXT_MASK      4'ha
`define IHS_EXT_ATA       4'hb
`define IHS_BIT_MEM_EN    0
`define IHS_BIT_IO_EN     6
`define IHS_IO_TS_STEP    4
`define IHS_BIT_MEM_TS    0
`define IHS_MASK_NONE     2'h0
`define IHS_MASK_DROP7    2'h1
`define IHS_MASK_ONLY7    2'h2
`define IHS_OE_NONE       16'h0000
`define IHS_OE_LOW        16'h00ff
`define IHS_OE_HIGH       16'hff00
`define IHS_OE_WORD       16'hffff
`define IHS_OE_DROP7      16'hff7f
`define IHS_OE_ONLY7      16'h0080
`define IHS_RST_VAL       8'h00
`define IHS_TS0_SETUP     8'h01
`define IHS_TS0_CMD       8'h06
`define IHS_TS0_RECOV     8'h00
`define IHS_TS1_SETUP     8'h01
`define IHS_TS1_CMD       8'h0c
`define IHS_TS1_RECOV     8'h00
`endif

/* core/ihs_host_port.v */
`include "ihs_consts.vh"
`default_nettype none
module ihs_host_port (
	input  wire        clk_sys_i,
	input  wire        rst_b_i,
	input  wire        power_good_input_i,
	input  wire        speaker_or_chip_select_pin_i,
	input  wire        aen_i,
	input  wire [23:0] sa_i,
	input  wire        sbhe_b_i,
	input  wire        ior_b_i,
	input  wire        iow_b_i,
	input  wire        memr_b_i,
	input  wire        memw_b_i,
	input  wire [15:0] sd_i,
	output reg  [15:0] sd_o,
	output reg  [15:0] sd_oe_o,
	output reg         iocs16_b_o,
	output reg         memcs16_b_o,
	input  wire [15:0] card_rdata_i,
	output reg         card_req_o,
	output reg         card_write_o,
	output reg         card_io_o,
	output reg         card_sock_o,
	output reg  [1:0]  card_be_o,
	output reg  [15:0] card_wdata_o,
	output reg  [7:0]  card_setup_o,
	output reg  [7:0]  card_cmd_o,
	output reg  [7:0]  card_recov_o
);

// ====================================================================
// Storage.
reg [7:0] rf  [0:`IHS_RF_DEPTH-1];
reg [7:0] ext [0:`IHS_EXT_DEPTH-1];
reg [7:0] index;
reg       mode16;
reg       strap;
reg       pg_q;
reg       ior_q;
reg       iow_q;
reg       memr_q;
reg       memw_q;
integer   i;
integer   k;

// ====================================================================
// Functions.
function [31:0] ihs_lanes;
	input        m16;
	input        sbhe_b;
	input        a0;
	input [15:0] d;
	begin
		if (!m16)
			ihs_lanes = {`IHS_OE_LOW, 8'h00, (a0 ? d[15:8] : d[7:0])};
		else if (!sbhe_b && !a0)
			ihs_lanes = {`IHS_OE_WORD, d};
		else if (!sbhe_b)
			ihs_lanes = {`IHS_OE_HIGH, d[15:8], 8'h00};
		else if (!a0)
			ihs_lanes = {`IHS_OE_LOW, 8'h00, d[7:0]};
		else
			ihs_lanes = {`IHS_OE_NONE, 16'h0000};
	end
endfunction

function ihs_is_rst;
	input [6:0] idx;
	reg   [6:0] low;
	begin
		low = idx & `IHS_SOCK_MASK;
		ihs_is_rst = (low == `IHS_IDX_WIN_EN) || (low == `IHS_IDX_IO_CTL) ||
			(low == `IHS_IDX_MEM_CTL) || (low == `IHS_IDX_SEC_INDEX);
	end
endfunction

function [7:0] ihs_tim_val;
	input [6:0] idx;
	reg   [6:0] off;
	begin
		off = (idx & `IHS_SOCK_MASK) - `IHS_IDX_TIM;
		if (off == 7'h00)
			ihs_tim_val = `IHS_TS0_SETUP;
		else if (off == 7'h01)
			ihs_tim_val = `IHS_TS0_CMD;
		else if (off == 7'h02)
			ihs_tim_val = `IHS_TS0_RECOV;
		else if (off == 7'h03)
			ihs_tim_val = `IHS_TS1_SETUP;
		else if (off == 7'h04)
			ihs_tim_val = `IHS_TS1_CMD;
		else
			ihs_tim_val = `IHS_TS1_RECOV;
	end
endfunction

// ====================================================================
// Host address decode.
wire        bus_ok   = !aen_i;
wire [15:0] io_a     = sa_i[15:0];
wire [15:0] idx_base = strap ? `IHS_IDX_PORT_ALT : `IHS_IDX_PORT;
wire        hit_idx  = bus_ok && (io_a == idx_base);
wire        hit_dat  = bus_ok && (io_a == (idx_base | `IHS_PORT_ODD));
wire        ata_addr = (io_a == `IHS_ATA_ADDR0) || (io_a == `IHS_ATA_ADDR1);
wire        ior_go   = !ior_b_i && ior_q;
wire        iow_go   = !iow_b_i && iow_q;
wire        memr_go  = !memr_b_i && memr_q;
wire        memw_go  = !memw_b_i && memw_q;
wire        cyc_io   = !ior_b_i || !iow_b_i;
wire        reg_wr   = iow_go && hit_dat;
wire [7:0]  sec      = rf[`IHS_IDX_SEC_INDEX];
wire        sec_ok   = (sec[7:4] == 4'h0);
wire        pg_rise  = power_good_input_i && !pg_q;

// ====================================================================
// Window decode per socket.
wire [3:0] io_hit;
wire [3:0] io_ts;
wire [1:0] mem_hit;
wire [1:0] mem_ts;
genvar s;
genvar w;
generate
	for (s = 0; s < 2; s = s + 1)
	begin : g_sock
		localparam integer SB = s * `IHS_SOCK_STRIDE;
		for (w = 0; w < 2; w = w + 1)
		begin : g_io
			localparam integer WB = SB + `IHS_IDX_IO_WIN + w * `IHS_IO_WIN_STEP;
			assign io_hit[s*2+w] = bus_ok && rf[SB+`IHS_IDX_WIN_EN][`IHS_BIT_IO_EN+w] &&
				(io_a >= {rf[WB+1], rf[WB]}) && (io_a <= {rf[WB+3], rf[WB+2]});
			assign io_ts[s*2+w] = rf[SB+`IHS_IDX_IO_CTL][w*`IHS_IO_TS_STEP];
		end
		assign mem_hit[s] = bus_ok && rf[SB+`IHS_IDX_WIN_EN][`IHS_BIT_MEM_EN] &&
			(sa_i[23:16] >= rf[SB+`IHS_IDX_MEM_START]) &&
			(sa_i[23:16] <= rf[SB+`IHS_IDX_MEM_STOP]);
		assign mem_ts[s] = rf[SB+`IHS_IDX_MEM_CTL][`IHS_BIT_MEM_TS];
	end
endgenerate

// ====================================================================
// Window selection, timing set and data mask.
reg        io_any;
reg [1:0]  sel_io;
reg        sel_sock;
reg        sel_ts;
reg [1:0]  mask_mode;
reg [15:0] io_mask;
reg [7:0]  ext_rd;
reg [7:0]  rdata;
integer    tb;

always @*
begin
	io_any = 1'b0;
	sel_io = 2'h0;
	for (k = 3; k >= 0; k = k - 1)
	begin
		if (io_hit[k])
		begin
			io_any = 1'b1;
			sel_io = k[1:0];
		end
	end
	sel_sock = cyc_io ? sel_io[1] : !mem_hit[0];
	sel_ts = cyc_io ? io_ts[sel_io] : mem_ts[!mem_hit[0]];
	tb = sel_sock * `IHS_SOCK_STRIDE + `IHS_IDX_TIM + sel_ts * `IHS_TIM_STEP;
	mask_mode = ext[`IHS_EXT_MASK][{sel_io, 1'b0} +: 2];
	if (ext[`IHS_EXT_ATA][sel_io[1]] && (mask_mode == `IHS_MASK_NONE))
		mask_mode = `IHS_MASK_DROP7;
	if (!ata_addr)
		io_mask = `IHS_OE_WORD;
	else if (mask_mode == `IHS_MASK_DROP7)
		io_mask = `IHS_OE_DROP7;
	else if (mask_mode == `IHS_MASK_ONLY7)
		io_mask = `IHS_OE_ONLY7;
	else
		io_mask = `IHS_OE_WORD;
	if (!sec_ok)
		ext_rd = 8'h00;
	else if (sec[3:0] == `IHS_EXT_STAT)
		ext_rd = {6'h00, strap, mode16};
	else
		ext_rd = ext[sec[3:0]];
	if (index[7])
		rdata = 8'h00;
	else if (index[6:0] == `IHS_IDX_SEC_DATA)
		rdata = ext_rd;
	else
		rdata = rf[index[6:0]];
end

wire        mem_any = |mem_hit;
wire [31:0] rd_ln   = ihs_lanes(mode16, sbhe_b_i, sa_i[0], card_rdata_i);
wire [31:0] wr_ln   = ihs_lanes(mode16, sbhe_b_i, sa_i[0], sd_i);
wire [1:0]  wr_be   = mode16 ? {wr_ln[31], wr_ln[16]} : {sa_i[0], !sa_i[0]};

// ====================================================================
// Register file.
always @(posedge clk_sys_i)
begin
	if (!rst_b_i)
	begin
		for (i = 0; i < `IHS_RF_DEPTH; i = i + 1)
		begin
			if (ihs_is_rst(i[6:0]))
				rf[i] <= `IHS_RST_VAL;
		end
		for (i = 0; i < `IHS_EXT_DEPTH; i = i + 1)
			ext[i] <= `IHS_RST_VAL;
	end
	else
	begin
		for (i = 0; i < `IHS_RF_DEPTH; i = i + 1)
		begin
			if (pg_rise && ((i[6:0] & `IHS_SOCK_MASK) >= `IHS_IDX_TIM))
				rf[i] <= ihs_tim_val(i[6:0]);
			else if (reg_wr && !index[7] && (index[6:0] == i[6:0]) && (i[6:0] != `IHS_IDX_SEC_DATA))
				rf[i] <= sd_i[7:0];
		end
		if (reg_wr && (index == {1'b0, `IHS_IDX_SEC_DATA}) && sec_ok && (sec[3:0] != `IHS_EXT_STAT))
			ext[sec[3:0]] <= sd_i[7:0];
	end
end

// ====================================================================
// Host cycle handling.
always @(posedge clk_sys_i)
begin
	if (!rst_b_i)
	begin
		index <= `IHS_RST_VAL;
		mode16 <= 1'b0;
		strap <= speaker_or_chip_select_pin_i;
		pg_q <= 1'b0;
		ior_q <= 1'b1;
		iow_q <= 1'b1;
		memr_q <= 1'b1;
		memw_q <= 1'b1;
		sd_o <= 16'h0000;
		sd_oe_o <= `IHS_OE_NONE;
		iocs16_b_o <= 1'b1;
		memcs16_b_o <= 1'b1;
		card_req_o <= 1'b0;
		card_write_o <= 1'b0;
		card_io_o <= 1'b0;
		card_sock_o <= 1'b0;
		card_be_o <= 2'h0;
		card_wdata_o <= 16'h0000;
		card_setup_o <= 8'h00;
		card_cmd_o <= 8'h00;
		card_recov_o <= 8'h00;
	end
	else
	begin
		ior_q <= ior_b_i;
		iow_q <= iow_b_i;
		memr_q <= memr_b_i;
		memw_q <= memw_b_i;
		pg_q <= power_good_input_i;
		if (bus_ok && !sbhe_b_i)
			mode16 <= 1'b1;
		iocs16_b_o <= !(mode16 && io_any);
		memcs16_b_o <= !(mode16 && mem_any);
		if (!ior_b_i && hit_idx)
		begin
			sd_o <= {8'h00, index};
			sd_oe_o <= `IHS_OE_LOW;
		end
		else if (!ior_b_i && hit_dat)
		begin
			sd_o <= {8'h00, rdata};
			sd_oe_o <= `IHS_OE_LOW;
		end
		else if (!ior_b_i && io_any)
		begin
			sd_o <= rd_ln[15:0];
			sd_oe_o <= rd_ln[31:16] & io_mask;
		end
		else if (!memr_b_i && mem_any)
		begin
			sd_o <= rd_ln[15:0];
			sd_oe_o <= rd_ln[31:16];
		end
		else
		begin
			sd_o <= 16'h0000;
			sd_oe_o <= `IHS_OE_NONE;
		end
		if (iow_go && hit_idx)
			index <= sd_i[7:0];
		card_req_o <= ((ior_go || iow_go) && io_any) || ((memr_go || memw_go) && mem_any);
		card_write_o <= iow_go || memw_go;
		card_io_o <= cyc_io;
		card_sock_o <= sel_sock;
		card_be_o <= wr_be;
		card_wdata_o <= mode16 ? wr_ln[15:0] : {sd_i[7:0], sd_i[7:0]};
		card_setup_o <= rf[tb];
		card_cmd_o <= rf[tb+1];
		card_recov_o <= rf[tb+2];
	end
end

endmodule
`default_nettype wire

/* verif/ihs_card_model.sv */
`default_nettype none
module ihs_card_model #(
	parameter logic [15:0] rd_word = 16'h0000
) (
	input  wire logic        card_sock_o,
	output var  logic [15:0] card_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Socket A answers with a fixed word; socket B shows its inverse.
	assign card_rdata_i = card_sock_o ? ~rd_word : rd_word;
endmodule
`default_nettype wire

/* verif/ihs_host_port_monitor.sv */
`include "ihs_consts.vh"
`default_nettype none
module ihs_host_port_monitor (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        speaker_or_chip_select_pin_i,
	input wire logic        aen_i,
	input wire logic [23:0] sa_i,
	input wire logic        sbhe_b_i,
	input wire logic        ior_b_i,
	input wire logic [15:0] sd_oe_o,
	input wire logic        iocs16_b_o,
	input wire logic        memcs16_b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic m16;
	logic st;
	wire  rh = !aen_i && {sa_i[15:1], 1'h0} == (st ? `IHS_IDX_PORT_ALT : `IHS_IDX_PORT);
	wire  rd = !aen_i && !ior_b_i;
	always @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			st <= speaker_or_chip_select_pin_i;
		m16 <= rst_b_i && (m16 || (!aen_i && !sbhe_b_i));
	end
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);
	a_low_lane_8bit: assert property (!m16 |-> sd_oe_o[15:8] == 8'h00) else $error("high lane");
	a_no_cs16_8bit: assert property (!m16 |-> iocs16_b_o && memcs16_b_o) else $error("cs16 early");
	a_odd_byte_lane: assert property ($past(m16 && rd && !sbhe_b_i && sa_i[0] && !rh) |-> sd_oe_o[7:0] == 8'h00)
		else $error("odd lane");
	a_even_byte_lane: assert property ($past(rd && sbhe_b_i && !sa_i[0]) |-> sd_oe_o[15:8] == 8'h00)
		else $error("even lane");
	a_reg_low_lane: assert property ($past(rd && rh && rst_b_i) |-> sd_oe_o == 16'h00ff)
		else $error("register lanes");
	a_reg_no_cs16: assert property ($past(rh) |-> iocs16_b_o) else $error("register cs16");
	a_read_release: assert property ($rose(ior_b_i) |=> sd_oe_o == 16'h0000) else $error("drive held");
	a_reset_quiet: assert property (!$past(rst_b_i) |-> sd_oe_o == 16'h0000 && iocs16_b_o && memcs16_b_o)
		else $error("reset drive");
endmodule
bind ihs_host_port ihs_host_port_monitor ihs_host_port_monitor_i (
	.clk_sys_i                    (clk_sys_i),
	.rst_b_i                      (rst_b_i),
	.speaker_or_chip_select_pin_i (speaker_or_chip_select_pin_i),
	.aen_i                        (aen_i),
	.sa_i                         (sa_i),
	.sbhe_b_i                     (sbhe_b_i),
	.ior_b_i                      (ior_b_i),
	.sd_oe_o                      (sd_oe_o),
	.iocs16_b_o                   (iocs16_b_o),
	.memcs16_b_o                  (memcs16_b_o)
);
`default_nettype wire

/* verif/test_isa_host_sizing_and_indexed_access.sv */
`include "ihs_consts.vh"
`default_nettype none
module test_isa_host_sizing_and_indexed_access;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] cw = 16'hc35a;
	localparam logic [23:0] ts0 = {`IHS_TS0_SETUP, `IHS_TS0_CMD, `IHS_TS0_RECOV};
	localparam logic [23:0] ts1 = {`IHS_TS1_SETUP, `IHS_TS1_CMD, `IHS_TS1_RECOV};
	logic        clk_sys_i = 1'h0, rst_b_i = 1'h0, power_good_input_i = 1'h0, aen_i = 1'h0;
	logic        sbhe_b_i = 1'h1, ior_b_i = 1'h1, iow_b_i = 1'h1, memr_b_i = 1'h1, memw_b_i = 1'h1;
	logic        speaker_or_chip_select_pin_i = 1'h0;
	logic [1:0]  cs;
	logic [20:0] req;
	logic [23:0] cmd;
	logic [23:0] sa_i = 24'h000000;
	logic [15:0] sd_i = 16'h0000, base = `IHS_IDX_PORT, q, oe;
	logic [7:0]  v;
	logic [7:0]  rf_m [0:127];
	logic [15:0] eo [4] = '{16'h00ff, 16'h007f, 16'h0080, 16'h007f};
	wire  [15:0] card_rdata_i, sd_o, sd_oe_o, card_wdata_o;
	wire  [7:0]  card_setup_o, card_cmd_o, card_recov_o;
	wire  [1:0]  card_be_o;
	wire         iocs16_b_o, memcs16_b_o, card_req_o, card_write_o, card_io_o, card_sock_o;
	int          error_cnt = 0, n_tests = 0;
	ihs_host_port ihs_host_port_i (
		.clk_sys_i                    (clk_sys_i),
		.rst_b_i                      (rst_b_i),
		.power_good_input_i           (power_good_input_i),
		.speaker_or_chip_select_pin_i (speaker_or_chip_select_pin_i),
		.aen_i                        (aen_i),
		.sa_i                         (sa_i),
		.sbhe_b_i                     (sbhe_b_i),
		.ior_b_i                      (ior_b_i),
		.iow_b_i                      (iow_b_i),
		.memr_b_i                     (memr_b_i),
		.memw_b_i                     (memw_b_i),
		.sd_i                         (sd_i),
		.sd_o                         (sd_o),
		.sd_oe_o                      (sd_oe_o),
		.iocs16_b_o                   (iocs16_b_o),
		.memcs16_b_o                  (memcs16_b_o),
		.card_rdata_i                 (card_rdata_i),
		.card_req_o                   (card_req_o),
		.card_write_o                 (card_write_o),
		.card_io_o                    (card_io_o),
		.card_sock_o                  (card_sock_o),
		.card_be_o                    (card_be_o),
		.card_wdata_o                 (card_wdata_o),
		.card_setup_o                 (card_setup_o),
		.card_cmd_o                   (card_cmd_o),
		.card_recov_o                 (card_recov_o)
	);
	ihs_card_model #(.rd_word(cw)) ihs_card_model_i (
		.card_sock_o  (card_sock_o),
		.card_rdata_i (card_rdata_i)
	);
	initial
	begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [23:0] a, input logic [7:0] d, input logic hb, input logic m = 1'h0);
		@(negedge clk_sys_i);
		sa_i = a;
		sbhe_b_i = hb;
		sd_i = {d, d};
		iow_b_i = !w || m;
		ior_b_i = w || m;
		memw_b_i = !w || !m;
		memr_b_i = w || !m;
		@(negedge clk_sys_i);
		req = {card_req_o, card_write_o, card_io_o, card_be_o, card_wdata_o};
		@(negedge clk_sys_i);
		{oe, q, cs, cmd} = {sd_oe_o, sd_o, memcs16_b_o, iocs16_b_o, card_setup_o, card_cmd_o, card_recov_o};
		{iow_b_i, ior_b_i, memw_b_i, memr_b_i, sbhe_b_i} = 5'h1f;
		@(negedge clk_sys_i);
	endtask
	task automatic wreg(input logic [6:0] i, input logic [7:0] d);
		acc(1'h1, base, {1'h0, i}, 1'h1);
		acc(1'h1, base + 16'h0001, d, 1'h1);
		rf_m[i] = d;
	endtask
	task automatic rreg(input logic [6:0] i);
		acc(1'h1, base, {1'h0, i}, 1'h1);
		acc(1'h0, base + 16'h0001, 8'h00, 1'h1);
		chk("reg", {16'h00ff, 8'h00, rf_m[i]}, {oe, 8'h00, q[7:0]});
	endtask
	task automatic reset_dut(input logic s);
		speaker_or_chip_select_pin_i = s;
		rst_b_i = 1'h0;
		repeat (8) @(negedge clk_sys_i);
		rst_b_i = 1'h1;
		power_good_input_i = 1'h1;
		foreach (rf_m[k])
			rf_m[k] = 8'h00;
		rf_m[`IHS_IDX_SEC_DATA] = {6'h00, s, 1'h0};
		{rf_m[7'h3a], rf_m[7'h3b], rf_m[7'h3c]} = {`IHS_TS0_SETUP, `IHS_TS0_CMD, `IHS_TS0_RECOV};
		{rf_m[7'h3d], rf_m[7'h3e], rf_m[7'h3f]} = {`IHS_TS1_SETUP, `IHS_TS1_CMD, `IHS_TS1_RECOV};
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'hdd232ae1));
		reset_dut(1'h0);
		for (int k = 0; k < 128; k += 64)
		begin
			rreg(7'(`IHS_IDX_WIN_EN + k));
			rreg(7'(`IHS_IDX_IO_CTL + k));
			rreg(7'(`IHS_IDX_MEM_CTL + k));
			rreg(7'(`IHS_IDX_SEC_INDEX + k));
		end
		for (int k = 0; k < 6; k++)
			rreg(7'(`IHS_IDX_TIM + k));
		$display("reset test done");
		v = 8'($urandom);
		wreg(`IHS_IDX_IO_WIN, v);
		wreg(7'(`IHS_IDX_IO_WIN + 64), ~v);
		rreg(`IHS_IDX_IO_WIN);
		acc(1'h0, base + 16'h0001, 8'h00, 1'h1);
		chk("held", {8'h00, v}, {8'h00, q[7:0]});
		rreg(7'(`IHS_IDX_IO_WIN + 64));
		$display("index test done");
		for (int k = 0; k < 4; k++)
			wreg(7'(`IHS_IDX_IO_WIN + k), k[0] ? 8'h03 : 8'hf6 + 8'(k[1]));
		wreg(`IHS_IDX_WIN_EN, 8'h40);
		for (int t = 0; t < 2; t++)
		begin
			wreg(`IHS_IDX_IO_CTL, 8'(t));
			acc(1'h0, `IHS_ATA_ADDR0, 8'h00, 1'h1);
			chk("odd8", {16'h00ff, 8'h00, cw[15:8]}, {oe, 8'h00, q[7:0]});
			chk("tset", t ? ts1 : ts0, cmd);
			chk("rreq", {3'h5, 2'h2, 16'h0000}, req);
			acc(1'h1, 16'h03f6, v, 1'h1);
			chk("wreq", {3'h7, 2'h1, v, v}, req);
		end
		for (int k = 0; k < 4; k++)
		begin
			wreg(`IHS_IDX_SEC_INDEX, {4'h0, `IHS_EXT_MASK});
			wreg(`IHS_IDX_SEC_DATA, k == 3 ? 8'h00 : 8'(k));
			wreg(`IHS_IDX_SEC_INDEX, {4'h0, `IHS_EXT_ATA});
			wreg(`IHS_IDX_SEC_DATA, 8'(k == 3));
			acc(1'h0, `IHS_ATA_ADDR0, 8'h00, 1'h1);
			chk("mask", eo[k], oe);
		end
		$display("mask test done");
		wreg(`IHS_IDX_SEC_INDEX, 8'h00);
		rf_m[`IHS_IDX_SEC_DATA] = 8'h00;
		rreg(`IHS_IDX_SEC_DATA);
		acc(1'h0, 16'h0100, 8'h00, 1'h0);
		rf_m[`IHS_IDX_SEC_DATA] = 8'h01;
		rreg(`IHS_IDX_SEC_DATA);
		acc(1'h0, 16'h03f6, 8'h00, 1'h0);
		chk("word", {16'hffff, cw}, {oe, q});
		chk("cs16", 2'h2, cs);
		chk("creq", {3'h5, 2'h3, 16'h0000}, req);
		acc(1'h0, `IHS_ATA_ADDR0, 8'h00, 1'h0);
		chk("upper", {16'hff00, cw[15:8]}, {oe, q[15:8]});
		acc(1'h0, `IHS_ATA_ADDR0, 8'h00, 1'h1);
		chk("none", 16'h0000, oe);
		aen_i = 1'h1;
		acc(1'h0, base + 16'h0001, 8'h00, 1'h1);
		aen_i = 1'h0;
		chk("aen", 16'h0000, oe);
		wreg(`IHS_IDX_MEM_START, 8'h0d);
		wreg(`IHS_IDX_MEM_STOP, 8'h0d);
		wreg(`IHS_IDX_WIN_EN, 8'h41);
		acc(1'h0, 24'h0d0000, 8'h00, 1'h0, 1'h1);
		chk("mem", {16'hffff, cw, 2'h1}, {oe, q, cs});
		chk("mreq", {3'h4, 2'h3, 16'h0000}, req);
		chk("mtim", ts0, cmd);
		$display("mode test done");
		reset_dut(1'h1);
		base = `IHS_IDX_PORT_ALT;
		rreg(`IHS_IDX_SEC_DATA);
		rreg(`IHS_IDX_WIN_EN);
		$display("strap test done");
		finish_test;
	end
endmodule
`default_nettype wire
